// File: design/asx_host_ctrl.v
// Host controller that sequences reads, writes and retention for a 16-bit asynchronous static memory
`timescale 1ns/100ps
`include "asx_consts.vh"

module asx_host_ctrl #(
	parameter ADDR_W = 17
) (
	// Clock and reset
	input  wire              MCLK,
	input  wire              RESET,
	// User request
	input  wire              REQ_VALID,
	input  wire              REQ_WRITE,
	input  wire [ADDR_W-1:0] REQ_ADDR,
	input  wire [15:0]       REQ_WDATA,
	input  wire [1:0]        REQ_LANES,
	output wire              REQ_READY,
	output reg  [15:0]       RSP_RDATA,
	output reg               RSP_VALID,
	// Retention control
	input  wire              RETAIN_REQ,
	output reg               RETAIN_SAFE,
	// Memory pins
	output reg  [ADDR_W-1:0] MEM_ADDR,
	output reg               MEM_CHIP_SEL_N,
	output reg               MEM_WRITE_N,
	output reg               MEM_OUT_EN_N,
	output reg               MEM_UPPER_BYTE_SEL_N,
	output reg               MEM_LOWER_BYTE_SEL_N,
	input  wire [15:0]       MEM_DQ_IN,
	output reg  [15:0]       MEM_DQ_OUT,
	output reg               MEM_DQ_OE
);

	localparam ST_IDLE   = 3'h0;
	localparam ST_READ   = 3'h1;
	localparam ST_WRITE  = 3'h2;
	localparam ST_WEND   = 3'h3;
	localparam ST_RETAIN = 3'h4;
	localparam ST_RECOV  = 3'h5;

	localparam integer RD_CYC_N  = `ASX_RD_CYC;
	localparam integer WR_CYC_N  = `ASX_WR_CYC;
	localparam integer REC_CYC_N = `ASX_REC_CYC;
	// Counts stay far below 16, so the cut to the counter width loses nothing
	localparam [3:0]   RD_CYC    = RD_CYC_N[3:0];
	localparam [3:0]   WR_CYC    = WR_CYC_N[3:0];
	localparam [3:0]   REC_CYC   = REC_CYC_N[3:0];

	reg [2:0]  state;
	reg [3:0]  count;
	reg        retain_meta;
	reg        retain_sync;
	reg [15:0] dq_meta;
	reg [15:0] dq_sync;
	wire [1:0]  lane_off;
	wire [15:0] lane_rdata;

	// Retention request comes from the supply manager, off this clock
	always @(posedge MCLK) begin
		if (RESET) begin
			retain_meta <= 1'b0;
			retain_sync <= 1'b0;
		end else begin
			retain_meta <= RETAIN_REQ;
			retain_sync <= retain_meta;
		end
	end

	// Read data is asynchronous to MCLK, so two stages before capture
	always @(posedge MCLK) begin
		if (RESET) begin
			dq_meta <= 16'h0000;
			dq_sync <= 16'h0000;
		end else begin
			dq_meta <= MEM_DQ_IN;
			dq_sync <= dq_meta;
		end
	end

	assign REQ_READY = (state == ST_IDLE) && !retain_sync;

	// Unselected lanes read as zero rather than whatever floats on the pins
	assign lane_off = {MEM_UPPER_BYTE_SEL_N, MEM_LOWER_BYTE_SEL_N};
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_lane
			assign lane_rdata[g*8 +: 8] = lane_off[g] ? 8'h00 : dq_sync[g*8 +: 8];
		end
	endgenerate

	always @(posedge MCLK) begin
		if (RESET) begin
			state                <= ST_IDLE;
			count                <= 4'h0;
			MEM_ADDR             <= {ADDR_W{1'b0}};
			MEM_CHIP_SEL_N       <= 1'b1;
			MEM_WRITE_N          <= 1'b1;
			MEM_OUT_EN_N         <= 1'b1;
			MEM_UPPER_BYTE_SEL_N <= 1'b1;
			MEM_LOWER_BYTE_SEL_N <= 1'b1;
			MEM_DQ_OUT           <= 16'h0000;
			MEM_DQ_OE            <= 1'b0;
			RSP_RDATA            <= 16'h0000;
			RSP_VALID            <= 1'b0;
			RETAIN_SAFE          <= 1'b0;
		end else begin
			RSP_VALID <= 1'b0;
			case (state)
			ST_IDLE: begin
				// Strobes rest high between accesses so the part sits in power-down
				MEM_CHIP_SEL_N       <= 1'b1;
				MEM_UPPER_BYTE_SEL_N <= 1'b1;
				MEM_LOWER_BYTE_SEL_N <= 1'b1;
				MEM_WRITE_N          <= 1'b1;
				MEM_OUT_EN_N         <= 1'b1;
				MEM_DQ_OE            <= 1'b0;
				if (retain_sync) begin
					state       <= ST_RETAIN;
					RETAIN_SAFE <= 1'b1;
				end else if (REQ_VALID && (REQ_LANES != 2'b00)) begin
					// An empty lane set selects nothing, so such a request is left waiting
					// Address, data and lanes settle with the strobes, zero setup allowed
					MEM_ADDR             <= REQ_ADDR;
					MEM_CHIP_SEL_N       <= 1'b0;
					MEM_UPPER_BYTE_SEL_N <= ~REQ_LANES[1];
					MEM_LOWER_BYTE_SEL_N <= ~REQ_LANES[0];
					count                <= 4'h1;
					if (REQ_WRITE) begin
						MEM_WRITE_N <= 1'b0;
						MEM_DQ_OUT  <= REQ_WDATA;
						MEM_DQ_OE   <= 1'b1;
						state       <= ST_WRITE;
					end else begin
						MEM_WRITE_N  <= 1'b1;
						MEM_OUT_EN_N <= 1'b0;
						state        <= ST_READ;
					end
				end
			end

			ST_READ: begin
				// Two extra cycles cover the input synchroniser; data is held steady by then
				if (count >= RD_CYC + 4'h2) begin
					state <= ST_IDLE;
					MEM_CHIP_SEL_N       <= 1'b1;
					MEM_UPPER_BYTE_SEL_N <= 1'b1;
					MEM_LOWER_BYTE_SEL_N <= 1'b1;
					MEM_OUT_EN_N         <= 1'b1;
					RSP_VALID            <= 1'b1;
					RSP_RDATA            <= lane_rdata;
				end else begin
					count <= count + 4'h1;
				end
			end

			ST_WRITE: begin
				// Address and data stay put across the whole pulse
				if (count >= WR_CYC) begin
					MEM_WRITE_N <= 1'b1;
					state       <= ST_WEND;
				end else begin
					count <= count + 4'h1;
				end
			end

			ST_WEND: begin
				// Data released and selects dropped only after the write strobe edge
				MEM_DQ_OE            <= 1'b0;
				MEM_CHIP_SEL_N       <= 1'b1;
				MEM_UPPER_BYTE_SEL_N <= 1'b1;
				MEM_LOWER_BYTE_SEL_N <= 1'b1;
				state                <= ST_IDLE;
			end

			ST_RETAIN: begin
				// Part stays deselected while the supply is lowered
				MEM_CHIP_SEL_N       <= 1'b1;
				MEM_UPPER_BYTE_SEL_N <= 1'b1;
				MEM_LOWER_BYTE_SEL_N <= 1'b1;
				if (!retain_sync) begin
					RETAIN_SAFE <= 1'b0;
					count       <= 4'h1;
					state       <= ST_RECOV;
				end
			end

			ST_RECOV: begin
				// Supply is back; accesses wait out the recovery time
				if (retain_sync) begin
					RETAIN_SAFE <= 1'b1;
					state       <= ST_RETAIN;
				end else if (count >= REC_CYC) begin
					state <= ST_IDLE;
				end else begin
					count <= count + 4'h1;
				end
			end

			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

endmodule // asx_host_ctrl

// File: design/asx_consts.vh
// Timing and layout constants for the static memory host controller
`ifndef ASX_CONSTS_VH
`define ASX_CONSTS_VH
`define ASX_CLK_PERIOD_NS         40
`define ASX_ADDR_ACCESS_NS        55
`define ASX_ADDR_CHANGE_HOLD_NS   10
`define ASX_ADDR_SETUP_END_NS     35
`define ASX_ADDR_HOLD_WR_NS       0
`define ASX_ADDR_SETUP_START_NS   0
`define ASX_WR_DATA_SETUP_NS      25
`define ASX_WR_DATA_HOLD_NS       0
`define ASX_WR_PULSE_NS           35
`define ASX_WR_CYCLE_NS           45
`define ASX_RECOVERY_NS           55
`define ASX_CEIL_CYC(ns)          (((ns) + `ASX_CLK_PERIOD_NS - 1) / `ASX_CLK_PERIOD_NS)
`define ASX_MIN1(c)               (((c) < 1) ? 1 : (c))
`define ASX_RD_CYC                `ASX_MIN1(`ASX_CEIL_CYC(`ASX_ADDR_ACCESS_NS))
`define ASX_WR_CYC                `ASX_MIN1(`ASX_CEIL_CYC(`ASX_WR_PULSE_NS))
`define ASX_REC_CYC               `ASX_MIN1(`ASX_CEIL_CYC(`ASX_RECOVERY_NS))
`define ASX_LOW_LANE_LSB          0
`define ASX_HIGH_LANE_LSB         8
`endif

// File: verif/asx_host_ctrl_properties.sv
// Concurrent checks on the host controller ports
`timescale 1ns/100ps
module asx_host_ctrl_properties #(parameter ADDR_W = 17) (
	input wire logic MCLK, RESET, REQ_VALID, REQ_WRITE, REQ_READY, RSP_VALID, RETAIN_SAFE,
	input wire logic [1:0] REQ_LANES,
	input wire logic [ADDR_W-1:0] MEM_ADDR,
	input wire logic MEM_CHIP_SEL_N, MEM_WRITE_N, MEM_OUT_EN_N, MEM_UPPER_BYTE_SEL_N, MEM_LOWER_BYTE_SEL_N, MEM_DQ_OE
);
	wire take = REQ_VALID && REQ_READY && |REQ_LANES;
	wire desel = MEM_CHIP_SEL_N || (MEM_UPPER_BYTE_SEL_N && MEM_LOWER_BYTE_SEL_N);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RESET);
	a_read_walk: assert property (take && !REQ_WRITE |=> (!desel && !MEM_OUT_EN_N)[*2] ##3 RSP_VALID)
		else $error("read timing");
	a_read_we_high: assert property (!MEM_OUT_EN_N |-> MEM_WRITE_N) else $error("write strobe in read");
	a_lane_map: assert property (take |=> {MEM_UPPER_BYTE_SEL_N, MEM_LOWER_BYTE_SEL_N} == ~$past(REQ_LANES))
		else $error("lane selects");
	a_write_start: assert property (take && REQ_WRITE |=> !MEM_WRITE_N && MEM_DQ_OE) else $error("write start");
	a_write_end_hold: assert property ($rose(MEM_WRITE_N) |-> MEM_DQ_OE && !desel && $stable(MEM_ADDR))
		else $error("write end hold");
	a_addr_held: assert property (!MEM_WRITE_N |=> $stable(MEM_ADDR)) else $error("address moved");
	a_write_select: assert property (!MEM_WRITE_N |-> !desel) else $error("write unselected");
	a_drive_sel: assert property (MEM_DQ_OE |-> !MEM_CHIP_SEL_N && MEM_OUT_EN_N) else $error("drive clash");
	a_retain_desel: assert property (RETAIN_SAFE |-> desel && MEM_WRITE_N) else $error("retention select");
	a_recovery_wait: assert property ($fell(RETAIN_SAFE) |-> !REQ_READY[*2]) else $error("recovery");
	c_read: cover property (take && !REQ_WRITE);
	c_write: cover property (take && REQ_WRITE);
	c_retain: cover property ($rose(RETAIN_SAFE));
	c_retain_again: cover property ($fell(RETAIN_SAFE) ##[1:3] RETAIN_SAFE);
endmodule // asx_host_ctrl_properties
bind asx_host_ctrl asx_host_ctrl_properties #(.ADDR_W(ADDR_W)) chk_u (.MCLK(MCLK), .RESET(RESET),
	.REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
	.RETAIN_SAFE(RETAIN_SAFE), .REQ_LANES(REQ_LANES), .MEM_ADDR(MEM_ADDR), .MEM_CHIP_SEL_N(MEM_CHIP_SEL_N),
	.MEM_WRITE_N(MEM_WRITE_N), .MEM_OUT_EN_N(MEM_OUT_EN_N), .MEM_UPPER_BYTE_SEL_N(MEM_UPPER_BYTE_SEL_N),
	.MEM_LOWER_BYTE_SEL_N(MEM_LOWER_BYTE_SEL_N), .MEM_DQ_OE(MEM_DQ_OE));

// File: verif/asx_sram_model.sv
// Behavioural 16-bit asynchronous static memory
`timescale 1ns/100ps
module asx_sram_model (
	input logic [16:0] a, input logic cs_n, we_n, oe_n, ub_n, lb_n, doe, input logic [15:0] d,
	output logic [15:0] q
);
	logic [15:0] mem [0:131071]; // Kept while deselected
	wire drv = !cs_n && !(ub_n && lb_n) && !oe_n && we_n;
	initial q = 16'h0000;
	// Blocking delays skip events inside the window; the last step rereads the pins, so a late change still lands
	always @(a, drv) begin
		#10 q = ~q;
		#45 q = drv ? mem[a] ^ {{8{ub_n}}, {8{lb_n}}} : ~q;
	end
	always @* if (!we_n && !cs_n && doe) begin
		if (!lb_n) mem[a][7:0] = d[7:0];
		if (!ub_n) mem[a][15:8] = d[15:8];
	end
endmodule // asx_sram_model

// File: verif/asx_host_ctrl_test.sv
// Self-checking bench for the host controller
`timescale 1ns/100ps
module asx_host_ctrl_test;
	logic MCLK, RESET, REQ_VALID, REQ_WRITE, REQ_READY, RSP_VALID, RETAIN_REQ, RETAIN_SAFE;
	logic cs_n, we_n, oe_n, ub_n, lb_n, doe;
	logic [16:0] REQ_ADDR, ma, a [8];
	logic [15:0] REQ_WDATA, RSP_RDATA, dq_i, dq_o, sh [0:131071], exp_q [$];
	logic [1:0] REQ_LANES;
	int fail_count, total_checks, i, seed;
	asx_host_ctrl dut_u (.MCLK(MCLK), .RESET(RESET), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE),
		.REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .REQ_LANES(REQ_LANES), .REQ_READY(REQ_READY),
		.RSP_RDATA(RSP_RDATA), .RSP_VALID(RSP_VALID), .RETAIN_REQ(RETAIN_REQ), .RETAIN_SAFE(RETAIN_SAFE),
		.MEM_ADDR(ma), .MEM_CHIP_SEL_N(cs_n), .MEM_WRITE_N(we_n), .MEM_OUT_EN_N(oe_n),
		.MEM_UPPER_BYTE_SEL_N(ub_n), .MEM_LOWER_BYTE_SEL_N(lb_n), .MEM_DQ_IN(dq_i), .MEM_DQ_OUT(dq_o), .MEM_DQ_OE(doe));
	asx_sram_model mem_u (.a(ma), .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n), .ub_n(ub_n), .lb_n(lb_n),
		.doe(doe), .d(dq_o), .q(dq_i));
	initial begin
		MCLK = 0;
		forever #20 MCLK = ~MCLK;
	end
	task test_done;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task cmp(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task to_fail(input logic ok);
		if (ok !== 1'b1) begin
			fail_count++;
			test_done;
		end
	endtask
	// Shadow copy is updated at issue; reads queue their expected word at issue
	task req(input logic w, input logic [16:0] ad, input logic [15:0] d, input logic [1:0] l);
		int k;
		@(negedge MCLK);
		{REQ_VALID, REQ_WRITE, REQ_ADDR, REQ_WDATA, REQ_LANES} = {1'b1, w, ad, d, l};
		for (k = 0; k < 20 && REQ_READY !== 1'b1; k++) @(negedge MCLK);
		to_fail(REQ_READY);
		if (w) sh[ad] = (sh[ad] & ~{{8{l[1]}}, {8{l[0]}}}) | (d & {{8{l[1]}}, {8{l[0]}}});
		else exp_q.push_back(sh[ad] & {{8{l[1]}}, {8{l[0]}}});
		@(negedge MCLK);
		REQ_VALID = 0;
	endtask
	always @(negedge MCLK) if (RSP_VALID === 1'b1) cmp(RSP_RDATA, exp_q.size() ? exp_q.pop_front() : 'x);
	initial begin
		seed = 90383;
		{REQ_VALID, REQ_WRITE, REQ_ADDR, REQ_WDATA, REQ_LANES, RETAIN_REQ} = '0;
		RESET = 1;
		repeat (6) @(negedge MCLK);
		RESET = 0;
		for (i = 0; i < 8; i++) begin
			a[i] = 17'($random(seed));
			req(1, a[i], 16'($random(seed)), 2'h3);
		end
		for (i = 0; i < 8; i++) req(1, a[i], 16'($random(seed)), 2'(i % 3 + 1));
		for (i = 0; i < 8; i++) req(0, a[i], 16'h0000, 2'(i % 3 + 1));
		// Empty lane set must never be taken, so no answer may appear
		@(negedge MCLK);
		{REQ_VALID, REQ_WRITE, REQ_LANES} = 4'h8;
		repeat (8) @(negedge MCLK);
		REQ_VALID = 0;
		RETAIN_REQ = 1;
		for (i = 0; i < 20 && RETAIN_SAFE !== 1'b1; i++) @(negedge MCLK);
		to_fail(RETAIN_SAFE);
		cmp({15'h0000, REQ_READY}, 16'h0000);
		// Supply returns, then is lowered again inside the recovery wait
		RETAIN_REQ = 0;
		repeat (2) @(negedge MCLK);
		RETAIN_REQ = 1;
		@(negedge MCLK);
		cmp({15'h0000, RETAIN_SAFE}, 16'h0000);
		for (i = 0; i < 20 && RETAIN_SAFE !== 1'b1; i++) @(negedge MCLK);
		to_fail(RETAIN_SAFE);
		cmp({15'h0000, REQ_READY}, 16'h0000);
		RETAIN_REQ = 0;
		for (i = 0; i < 20 && REQ_READY !== 1'b1; i++) @(negedge MCLK);
		to_fail(REQ_READY);
		cmp({15'h0000, RETAIN_SAFE}, 16'h0000);
		for (i = 0; i < 8; i++) req(0, a[i], 16'h0000, 2'h3);
		repeat (10) @(negedge MCLK);
		cmp(16'(exp_q.size()), 16'h0000);
		test_done;
	end
endmodule // asx_host_ctrl_test
